// *** ssp_pkg.sv ***
// constants for the serial memory programming slave
// Operation
// - programming works only while the device reset pin is held low
// - programming enable must come first; no write or erase before it
// - each eeprom byte write erases its location inside the timed cycle
// - chip erase sets every flash and eeprom location to all ones
// - input bits are sampled on the rising serial clock edge
// - output bits change on the falling serial clock edge
// - second enable byte echoes during the third; all four bytes always sent
// - page buffer loads one byte per instruction by six low address bits
// - write page commits buffer at page given by eight high address bits
// - eeprom programs one byte per write; programmer waits 9.0 ms
// - read instructions return the addressed location on serial output
// - reset pin going high ends programming mode
// - reads inside a page being written return all ones until done
// - eeprom location being written reads all ones until done
// - enable is bytes 1010 1100, 0101 0011, then two don't-care bytes
// - chip erase is 1010 1100 then a byte starting 100
// - eeprom read is 1010 0000; address in bytes two and three
// - eeprom write is 1100 0000; address then data byte
package ssp_pkg;
   localparam int CLK_MHZ = 100;
   localparam int FLASH_PAGE_MIN_WAIT_US = 4500;
   localparam int EEPROM_BYTE_MIN_WAIT_US = 9000;
   localparam int CHIP_ERASE_MIN_WAIT_US = 9000;
   localparam int FLASH_WAIT_CYC = FLASH_PAGE_MIN_WAIT_US * CLK_MHZ;
   localparam int EEPROM_WAIT_CYC = EEPROM_BYTE_MIN_WAIT_US * CLK_MHZ;
   localparam int ERASE_WAIT_CYC = CHIP_ERASE_MIN_WAIT_US * CLK_MHZ;
   localparam int FLASH_AW = 14;
   localparam int EE_AW = 10;
   localparam int PAGE_AW = 6;
   localparam int BITS_PER_INSTR = 32;
   localparam logic [7:0] OP_ENABLE = 8'hAC;
   localparam logic [7:0] OP_SYNC = 8'h53;
   localparam logic [2:0] OP_ERASE_B2 = 3'h4;
   localparam logic [7:0] OP_EE_READ = 8'hA0;
   localparam logic [7:0] OP_EE_WRITE = 8'hC0;
   localparam logic [7:0] OP_FL_WPAGE = 8'h4C;
   localparam logic [3:0] OP_FL_LOAD = 4'h4;
   localparam logic [3:0] OP_FL_READ = 4'h2;
   localparam logic [2:0] OP_H_LOW = 3'h0;
   localparam logic [7:0] ERASED = 8'hFF;
   localparam logic [7:0] ZERO8 = 8'h00;
   typedef enum logic [1:0] {ST_IDLE, ST_FLASH, ST_EEPROM, ST_ERASE} ssp_busy_t;
endpackage

// *** ssp_mem.sv ***
// byte memory with registered read port and a single write port
module ssp_mem #(
   parameter int AW = 10
) (
   input wire logic clk,
   input wire logic we,
   input wire logic [AW-1:0] wAddr,
   input wire logic [7:0] wData,
   input wire logic [AW-1:0] rAddr,
   output logic [7:0] rData
);
   logic [7:0] mem [0:(1<<AW)-1];

   always_ff @(posedge clk) begin
      if (we) begin
         mem[wAddr] <= wData;
      end
   end

   always_ff @(posedge clk) begin
      rData <= mem[rAddr];
   end
endmodule

// *** ssp_prog.sv ***
// serial programming slave for flash and eeprom, with arrays inside
module ssp_prog #(
   parameter int FLASH_WAIT = ssp_pkg::FLASH_WAIT_CYC,
   parameter int EEPROM_WAIT = ssp_pkg::EEPROM_WAIT_CYC,
   parameter int ERASE_WAIT = ssp_pkg::ERASE_WAIT_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic resetPinN,
   input wire logic sck,
   input wire logic mosi,
   output logic miso,
   output logic misoOe,
   output logic progActive,
   output logic busy
);
   localparam int FAW = ssp_pkg::FLASH_AW;
   localparam int EAW = ssp_pkg::EE_AW;
   localparam int PAW = ssp_pkg::PAGE_AW;

   // pin synchronisers: first stage read only by second
   logic [1:0] sckSync_q, mosiSync_q, rstPinSync_q;
   logic sckPrev_q;
   always_ff @(posedge clk) begin
      if (rst) begin
         sckSync_q <= 2'h0;
         mosiSync_q <= 2'h0;
         rstPinSync_q <= 2'h3;
         sckPrev_q <= 1'b0;
      end else begin
         sckSync_q <= {sckSync_q[0], sck};
         mosiSync_q <= {mosiSync_q[0], mosi};
         rstPinSync_q <= {rstPinSync_q[0], resetPinN};
         sckPrev_q <= sckSync_q[1];
      end
   end
   logic sckRise, sckFall, inProg;
   assign sckRise = sckSync_q[1] & ~sckPrev_q;
   assign sckFall = ~sckSync_q[1] & sckPrev_q;
   assign inProg = ~rstPinSync_q[1];

   // shift-in of 32 bits
   logic [31:0] shIn_q;
   logic [4:0] bitCnt_q;
   logic enabled_q;
   logic instrDone;
   assign instrDone = sckRise && bitCnt_q == 5'h1_F;
   always_ff @(posedge clk) begin
      if (rst || !inProg) begin
         shIn_q <= 32'h0000_0000;
         bitCnt_q <= 5'h0_0;
      end else if (sckRise) begin
         shIn_q <= {shIn_q[30:0], mosiSync_q[1]};
         bitCnt_q <= bitCnt_q + 5'h0_1;
      end
   end
   logic [31:0] word;
   assign word = {shIn_q[30:0], mosiSync_q[1]};
   logic [7:0] b1, b2, b3, b4;
   assign b1 = word[31:24];
   assign b2 = word[23:16];
   assign b3 = word[15:8];
   assign b4 = word[7:0];

   // two-entry buffer of decoded instructions; busy engine drains it
   logic fifoInValid, fifoInReady, fifoOutValid, fifoOutReady;
   logic [31:0] fifoMem_q [0:1];
   logic [1:0] fifoCnt_q;
   logic fifoWp_q, fifoRp_q;
   logic [31:0] cmd;
   assign fifoInReady = fifoCnt_q != 2'h2;
   assign fifoOutValid = fifoCnt_q != 2'h0;
   assign cmd = fifoMem_q[fifoRp_q];
   always_ff @(posedge clk) begin
      if (rst || !inProg) begin
         fifoCnt_q <= 2'h0;
         fifoWp_q <= 1'b0;
         fifoRp_q <= 1'b0;
      end else begin
         if (fifoInValid && fifoInReady) begin
            fifoMem_q[fifoWp_q] <= word;
            fifoWp_q <= ~fifoWp_q;
         end
         if (fifoOutValid && fifoOutReady) begin
            fifoRp_q <= ~fifoRp_q;
         end
         fifoCnt_q <= fifoCnt_q + 2'(fifoInValid && fifoInReady) -
            2'(fifoOutValid && fifoOutReady);
      end
   end

   // decode helpers
   function automatic logic isWrite(input logic [31:0] w);
      isWrite = (w[31:24] == ssp_pkg::OP_FL_WPAGE) || (w[31:24] == ssp_pkg::OP_EE_WRITE)
         || (w[31:28] == ssp_pkg::OP_FL_LOAD && w[26:24] == ssp_pkg::OP_H_LOW)
         || (w[31:24] == ssp_pkg::OP_ENABLE && w[23:21] == ssp_pkg::OP_ERASE_B2);
   endfunction
   function automatic logic isErase(input logic [31:0] w);
      isErase = w[31:24] == ssp_pkg::OP_ENABLE && w[23:21] == ssp_pkg::OP_ERASE_B2;
   endfunction

   // enable state: set by a complete enable instruction
   always_ff @(posedge clk) begin
      if (rst || !inProg) begin
         enabled_q <= 1'b0;
      end else if (instrDone && b1 == ssp_pkg::OP_ENABLE && b2 == ssp_pkg::OP_SYNC) begin
         enabled_q <= 1'b1;
      end
   end
   // writes queue only when enabled; an instruction lost to a full buffer is dropped
   assign fifoInValid = instrDone && enabled_q && !(b1 == ssp_pkg::OP_ENABLE
      && b2 == ssp_pkg::OP_SYNC) && isWrite(word);

   // page buffer: low/high byte per word, six address bits
   logic [7:0] pageLo_q [0:(1<<PAW)-1];
   logic [7:0] pageHi_q [0:(1<<PAW)-1];

   // busy engine
   ssp_pkg::ssp_busy_t st_q;
   logic [31:0] timer_q;
   logic [FAW-PAW-1:0] busyPage_q;
   logic [EAW-1:0] busyEe_q;
   logic [FAW:0] eraseIdx_q;
   logic [PAW:0] copyIdx_q;
   logic flWe, eeWe;
   logic [FAW:0] flWAddr;
   logic [7:0] flWData;
   logic [EAW-1:0] eeWAddr;
   logic [7:0] eeWData;
   logic [7:0] eeData_q;
   logic idle;
   assign idle = st_q == ssp_pkg::ST_IDLE;
   assign fifoOutReady = idle;
   assign busy = !idle;

   always_ff @(posedge clk) begin
      if (rst || !inProg) begin
         st_q <= ssp_pkg::ST_IDLE;
         timer_q <= 32'h0000_0000;
         busyPage_q <= '0;
         busyEe_q <= '0;
         eraseIdx_q <= '0;
         copyIdx_q <= '0;
      end else begin
         unique case (st_q)
            ssp_pkg::ST_IDLE: begin
               if (fifoOutValid) begin
                  if (isErase(cmd)) begin
                     st_q <= ssp_pkg::ST_ERASE;
                     timer_q <= 32'(ERASE_WAIT);
                     eraseIdx_q <= '0;
                  end else if (cmd[31:24] == ssp_pkg::OP_FL_WPAGE) begin
                     st_q <= ssp_pkg::ST_FLASH;
                     timer_q <= 32'(FLASH_WAIT);
                     busyPage_q <= {cmd[21:16], cmd[15:14]};
                     copyIdx_q <= '0;
                  end else if (cmd[31:24] == ssp_pkg::OP_EE_WRITE) begin
                     st_q <= ssp_pkg::ST_EEPROM;
                     timer_q <= 32'(EEPROM_WAIT);
                     busyEe_q <= {cmd[17:16], cmd[15:8]};
                  end else begin
                     pageBufWrite(cmd);
                  end
               end
            end
            default: begin
               if (st_q == ssp_pkg::ST_ERASE && !eraseIdx_q[FAW]) begin
                  eraseIdx_q <= eraseIdx_q + 1'b1;
               end
               if (st_q == ssp_pkg::ST_FLASH && !copyIdx_q[PAW]) begin
                  copyIdx_q <= copyIdx_q + 1'b1;
               end
               // a short timer must not cut the array walk of an erase or page copy
               if (timer_q <= 32'h0000_0001) begin
                  if ((st_q != ssp_pkg::ST_ERASE || eraseIdx_q[FAW])
                     && (st_q != ssp_pkg::ST_FLASH || copyIdx_q[PAW])) begin
                     st_q <= ssp_pkg::ST_IDLE;
                  end
               end else begin
                  timer_q <= timer_q - 32'h0000_0001;
               end
            end
         endcase
      end
   end

   task automatic pageBufWrite(input logic [31:0] w);
      if (w[27]) begin
         pageHi_q[w[13:8]] <= w[7:0];
      end else begin
         pageLo_q[w[13:8]] <= w[7:0];
      end
   endtask

   // array write ports; flWAddr holds word*2 for a page copy and the word itself for erase, and each flash byte array is indexed by word
   always_comb begin
      flWe = 1'b0;
      flWAddr = '0;
      flWData = ssp_pkg::ERASED;
      eeWe = 1'b0;
      eeWAddr = busyEe_q;
      eeWData = ssp_pkg::ERASED;
      if (st_q == ssp_pkg::ST_ERASE && !eraseIdx_q[FAW]) begin
         flWe = 1'b1;
         flWAddr = {1'b0, eraseIdx_q[FAW-1:0]};
         eeWe = 1'b1;
         eeWAddr = eraseIdx_q[EAW-1:0];
      end else if (st_q == ssp_pkg::ST_FLASH && !copyIdx_q[PAW]) begin
         flWe = 1'b1;
         flWAddr = {busyPage_q, copyIdx_q[PAW-1:0], 1'b0};
         flWData = pageLo_q[copyIdx_q[PAW-1:0]];
      end else if (st_q == ssp_pkg::ST_EEPROM && timer_q == 32'h0000_0001) begin
         eeWe = 1'b1;
         eeWData = eeData_q;
      end
   end

   // high bytes are written in the same copy cycle as low, into the separate high array
   always_ff @(posedge clk) begin
      if (rst) begin
         eeData_q <= ssp_pkg::ERASED;
      end else if (idle && fifoOutValid && cmd[31:24] == ssp_pkg::OP_EE_WRITE) begin
         eeData_q <= cmd[7:0];
      end
   end
   logic flHiWe;
   assign flHiWe = st_q == ssp_pkg::ST_FLASH && !copyIdx_q[PAW];

   // flash as two byte arrays (low/high) of word address width
   logic [FAW-1:0] flRAddr;
   logic [EAW-1:0] eeRAddr;
   logic [7:0] flLoRd, flHiRd, eeRd;
   ssp_mem #(.AW(FAW)) uFlLo (
      .clk(clk),
      .we(flWe),
      .wAddr(st_q == ssp_pkg::ST_ERASE ? flWAddr[FAW-1:0] : flWAddr[FAW:1]),
      .wData(flWData),
      .rAddr(flRAddr),
      .rData(flLoRd)
   );
   ssp_mem #(.AW(FAW)) uFlHi (
      .clk(clk),
      .we(flWe),
      .wAddr(st_q == ssp_pkg::ST_ERASE ? flWAddr[FAW-1:0] : flWAddr[FAW:1]),
      .wData(flHiWe ? pageHi_q[copyIdx_q[PAW-1:0]] : ssp_pkg::ERASED),
      .rAddr(flRAddr),
      .rData(flHiRd)
   );
   ssp_mem #(.AW(EAW)) uEe (
      .clk(clk),
      .we(eeWe),
      .wAddr(eeWAddr),
      .wData(eeWData),
      .rAddr(eeRAddr),
      .rData(eeRd)
   );

   // read path: address captured after byte three, data loaded at byte four
   logic [4:0] bitCnt;
   assign bitCnt = bitCnt_q;
   // after 24 bits the second and third bytes sit in the low 16 bits
   assign flRAddr = {shIn_q[13:8], shIn_q[7:0]};
   assign eeRAddr = {shIn_q[9:8], shIn_q[7:0]};
   logic [7:0] shOut_q;
   function automatic logic [7:0] readByte(input logic [7:0] op, input logic [7:0] lo,
      input logic [7:0] hi, input logic [7:0] ee, input logic fBusy, input logic eBusy);
      if (op == ssp_pkg::OP_EE_READ) begin
         readByte = eBusy ? ssp_pkg::ERASED : ee;
      end else if (op[7:4] == ssp_pkg::OP_FL_READ && op[2:0] == ssp_pkg::OP_H_LOW) begin
         readByte = fBusy ? ssp_pkg::ERASED : (op[3] ? hi : lo);
      end else begin
         readByte = ssp_pkg::ZERO8;
      end
   endfunction
   logic flHit, eeHit;
   assign flHit = st_q == ssp_pkg::ST_ERASE || (st_q == ssp_pkg::ST_FLASH
      && flRAddr[FAW-1:PAW] == busyPage_q);
   assign eeHit = st_q == ssp_pkg::ST_ERASE || (st_q == ssp_pkg::ST_EEPROM
      && eeRAddr == busyEe_q);
   logic [7:0] rdByte;
   assign rdByte = readByte(shIn_q[23:16], flLoRd, flHiRd, eeRd, flHit, eeHit);

   always_ff @(posedge clk) begin
      if (rst || !inProg) begin
         shOut_q <= ssp_pkg::ZERO8;
         miso <= 1'b0;
      end else if (sckFall) begin
         if (bitCnt == 5'h1_0 && shIn_q[15:8] == ssp_pkg::OP_ENABLE) begin
            miso <= shIn_q[7];
            shOut_q <= {shIn_q[6:0], 1'b0};
         end else if (bitCnt == 5'h1_8) begin
            miso <= rdByte[7];
            shOut_q <= {rdByte[6:0], 1'b0};
         end else begin
            miso <= shOut_q[7];
            shOut_q <= {shOut_q[6:0], 1'b0};
         end
      end
   end
   assign misoOe = inProg;
   assign progActive = enabled_q;
endmodule

// *** ssp_prog_props.sv ***
// checker of link timing and programming state at the slave ports
module ssp_prog_props #(
   parameter int FLASH_WAIT = 50,
   parameter int EEPROM_WAIT = 50,
   parameter int ERASE_WAIT = 50
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic resetPinN,
   input wire logic sck,
   input wire logic mosi,
   input wire logic miso,
   input wire logic misoOe,
   input wire logic progActive,
   input wire logic busy
);
   // erase walks every flash word even when its timer is shorter
   localparam int MAX_BUSY = FLASH_WAIT + EEPROM_WAIT + ERASE_WAIT
      + (1 << ssp_pkg::FLASH_AW) + 16;
   logic sckQ;
   logic [3:0] sinceFallQ;
   int busyCntQ;
   // cycles since the raw serial clock last fell
   always_ff @(posedge clk) begin
      sckQ <= sck;
      if (rst)
         sinceFallQ <= 4'hf;
      else if (sckQ && !sck)
         sinceFallQ <= 4'h0;
      else if (sinceFallQ != 4'hf)
         sinceFallQ <= sinceFallQ + 4'h1;
   end
   always_ff @(posedge clk) begin
      busyCntQ <= (busy && !rst) ? busyCntQ + 1 : 0;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   chk_oe_pin_high: assert property (resetPinN [*5] |-> !misoOe)
      else $error("output enable high with reset pin released");
   chk_oe_pin_low: assert property (!resetPinN [*5] |-> misoOe)
      else $error("output enable low in programming mode");
   chk_active_ends: assert property (resetPinN [*5] |-> !progActive)
      else $error("programming mode kept after reset pin release");
   chk_active_cause: assert property ($rose(progActive) |-> misoOe)
      else $error("programming enabled outside reset");
   chk_busy_cause: assert property ($rose(busy) |-> progActive)
      else $error("write started before enable");
   chk_busy_min: assert property ($rose(busy) |-> busy [*8])
      else $error("write timer ended too early");
   chk_busy_bound: assert property (busyCntQ <= MAX_BUSY)
      else $error("write timer never ends");
   chk_miso_on_fall: assert property (misoOe && $past(misoOe) && $changed(miso)
      |-> sinceFallQ < 4'h7)
      else $error("output bit changed away from a clock fall");
endmodule

bind ssp_prog ssp_prog_props #(.FLASH_WAIT(FLASH_WAIT), .EEPROM_WAIT(EEPROM_WAIT),
   .ERASE_WAIT(ERASE_WAIT)) ssp_prog_props_inst (.clk(clk), .rst(rst),
   .resetPinN(resetPinN), .sck(sck), .mosi(mosi), .miso(miso), .misoOe(misoOe),
   .progActive(progActive), .busy(busy));

// *** ssp_programmer.sv ***
// programmer model driving reset pin and serial link
module ssp_programmer #(
   parameter int HALF = 8
) (
   input wire logic clk,
   output logic resetPinN,
   output logic sck,
   output logic mosi,
   input wire logic miso
);
   initial begin
      resetPinN = 1'b1;
      sck = 1'b0;
      mosi = 1'b0;
   end
   task automatic pin(input logic v);
      @(posedge clk);
      resetPinN <= v;
   endtask
   // always all 32 bits; clock stays low between frames
   task automatic xfer(input logic [31:0] cmd, output logic [7:0] b3, output logic [7:0] b4);
      logic [31:0] rx;
      rx = '0;
      for (int i = 31; i >= 0; i--) begin
         @(posedge clk);
         mosi <= cmd[i];
         repeat (HALF) @(posedge clk);
         sck <= 1'b1;
         rx[i] = miso;
         repeat (HALF) @(posedge clk);
         sck <= 1'b0;
      end
      @(posedge clk);
      // stale data line must never look like a valid bit
      mosi <= ~mosi;
      b3 = rx[15:8];
      b4 = rx[7:0];
      repeat (4) @(posedge clk);
   endtask
endmodule

// *** tb_ssp_prog.sv ***
// self-checking bench for the serial programming slave
module tb_ssp_prog;
   timeunit 1ns;
   timeprecision 1ps;
   // long enough that a read right after a write still lands in the busy window
   localparam int WAIT = 1000;
   logic clk, rst, resetPinN, sck, mosi, miso, misoOe, progActive, busy;
   int err_total, n_tests;
   logic [7:0] r3, r4, d, d2;
   logic [9:0] ea;
   logic [13:0] fa;
   ssp_prog #(.FLASH_WAIT(WAIT), .EEPROM_WAIT(WAIT), .ERASE_WAIT(WAIT)) ssp_prog_inst (
      .clk(clk), .rst(rst), .resetPinN(resetPinN), .sck(sck), .mosi(mosi), .miso(miso),
      .misoOe(misoOe), .progActive(progActive), .busy(busy));
   ssp_programmer ssp_programmer_inst (.clk(clk), .resetPinN(resetPinN), .sck(sck),
      .mosi(mosi), .miso(miso));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   function automatic logic [31:0] eeCmd(input logic [7:0] op, input logic [9:0] a,
      input logic [7:0] v);
      return {op, 6'h00, a, v};
   endfunction
   function automatic logic [31:0] flCmd(input logic [7:0] op, input logic [13:0] a,
      input logic [7:0] v);
      return {op, 2'h0, a, v};
   endfunction
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic send(input logic [31:0] cmd);
      ssp_programmer_inst.xfer(cmd, r3, r4);
   endtask
   task automatic waitIdle;
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 20000) begin
         @(posedge clk);
         n++;
      end
      chk({7'h00, busy}, 8'h00, "busy cleared");
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (90000) @(posedge clk);
      err_total++;
      end_sim;
   end
   initial begin
      rst = 1'b1;
      err_total = 0;
      n_tests = 0;
      void'($urandom(32'hf5167d25));
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      ssp_programmer_inst.pin(1'b0);
      repeat (20) @(posedge clk);
      ea = 10'($urandom);
      send(eeCmd(ssp_pkg::OP_EE_WRITE, ea, 8'h5a));
      chk({7'h00, busy}, 8'h00, "write before enable");
      send({ssp_pkg::OP_ENABLE, ssp_pkg::OP_SYNC, 16'($urandom)});
      chk(r3, ssp_pkg::OP_SYNC, "enable echo");
      chk({7'h00, progActive}, 8'h01, "enabled");
      send({ssp_pkg::OP_ENABLE, ssp_pkg::OP_ERASE_B2, 5'($urandom), 16'($urandom)});
      chk({7'h00, busy}, 8'h01, "erase busy");
      waitIdle();
      send(eeCmd(ssp_pkg::OP_EE_READ, ea, 8'h00));
      chk(r4, ssp_pkg::ERASED, "eeprom erased");
      fa = 14'($urandom);
      send(flCmd(8'h28, fa, 8'h00));
      chk(r4, ssp_pkg::ERASED, "flash erased");
      for (int k = 0; k < 4; k++) begin
         ea = (k == 0) ? 10'h3ff : 10'($urandom);
         d = 8'($urandom % 255);
         send(eeCmd(ssp_pkg::OP_EE_WRITE, ea, d));
         send(eeCmd(ssp_pkg::OP_EE_READ, ea, 8'h00));
         chk(r4, ssp_pkg::ERASED, "eeprom poll");
         waitIdle();
         send(eeCmd(ssp_pkg::OP_EE_READ, ea, 8'h00));
         chk(r4, d, "eeprom data");
         d2 = ~d;
         send(eeCmd(ssp_pkg::OP_EE_WRITE, ea, d2));
         waitIdle();
         send(eeCmd(ssp_pkg::OP_EE_READ, ea, 8'h00));
         chk(r4, d2, "eeprom rewrite");
      end
      for (int k = 0; k < 2; k++) begin
         fa = (k == 0) ? 14'h3fff : 14'($urandom);
         // never all ones, so polling stays meaningful
         d = 8'($urandom % 255);
         d2 = 8'($urandom % 255);
         send(flCmd(8'h40, {8'h00, fa[5:0]}, d));
         send(flCmd(8'h48, {8'h00, fa[5:0]}, d2));
         send(flCmd(ssp_pkg::OP_FL_WPAGE, fa, 8'h00));
         send(flCmd(8'h20, fa, 8'h00));
         chk(r4, ssp_pkg::ERASED, "flash poll");
         waitIdle();
         send(flCmd(8'h20, fa, 8'h00));
         chk(r4, d, "flash low byte");
         send(flCmd(8'h28, fa, 8'h00));
         chk(r4, d2, "flash high byte");
      end
      ssp_programmer_inst.pin(1'b1);
      repeat (8) @(posedge clk);
      chk({7'h00, progActive}, 8'h00, "enable dropped by pulse");
      ssp_programmer_inst.pin(1'b0);
      repeat (20) @(posedge clk);
      send({ssp_pkg::OP_ENABLE, ssp_pkg::OP_SYNC, 16'($urandom)});
      chk(r3, ssp_pkg::OP_SYNC, "echo after resync");
      send(flCmd(8'h20, fa, 8'h00));
      chk(r4, d, "flash kept over resync");
      ssp_programmer_inst.pin(1'b1);
      repeat (8) @(posedge clk);
      chk({7'h00, progActive}, 8'h00, "session end");
      chk({7'h00, misoOe}, 8'h00, "output released");
      end_sim;
   end
endmodule
